// >>> dv/sbyc_cpu_model.sv
// Purpose: CPU core model facing the standby controller
// Assumes: ack_valid and cpu_resume are one-cycle pulses
// Notes:   Routine status comes from the bench, which changes it within scenarios
module sbyc_cpu_model
  import sbyc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] cfg,
  input  wire logic       ack_valid,
  input  wire sbyc_src_t  ack_src,
  input  wire logic       cpu_resume,
  output logic            nmi_blocked,
  output logic            isr_busy,
  output logic [1:0]      isr_level,
  output int              ack_cnt,
  output int              res_cnt,
  output sbyc_src_t       last_src
);
  timeunit 1ns;
  timeprecision 1ns;

  // Routine status held as levels, like the core's status flags
  assign {nmi_blocked, isr_busy, isr_level} = cfg;

  // Counts let the bench see pulses it would miss between checks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_cnt  <= 0;
      res_cnt  <= 0;
      last_src <= SBYC_ACK_NMI;
    end else begin
      if (ack_valid) begin
        ack_cnt  <= ack_cnt + 1;
        last_src <= ack_src;
      end
      if (cpu_resume) begin
        res_cnt <= res_cnt + 1;
      end
    end
  end
endmodule : sbyc_cpu_model

// >>> dv/tb.sv
// Purpose: Self-checking bench for the deep standby controller
// Assumes: Settle base shortened to 4 cycles
// Notes:   Pin edges programmed rising; pins idle low
module tb import sbyc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SET_EXP = 16;
  logic        clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, mov = 1'h0, wt = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'h0, cfg = 4'h0;
  logic [2:0]  pins = 3'h0;
  logic        pready, pslverr, ack_valid, cpu_resume, rvf, ram_keep, osc_en, sce, io_hold, bde, err;
  logic        rlh, hri, hafl, oig, conv_run, conv_pw, nmib, busy;
  logic [1:0]  lvl;
  sbyc_src_t   ack_src, last_src;
  int          ack_cnt, res_cnt, a0 = 0, r0 = 0, n, cyc = 0, bad_count = 0, n_tests = 0;

  initial forever #5 clk = ~clk;

  sbyc_top #(.SETTLE_BASE_CYC(20'h00004)) dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mov_imm_wr(mov), .nmi_pin(pins[0]), .ext_request_a(pins[1]), .ext_request_b(pins[2]),
    .watch_timer_request(wt), .nmi_blocked(nmib), .isr_busy(busy), .isr_level(lvl), .ack_valid(ack_valid),
    .ack_src(ack_src), .cpu_resume(cpu_resume), .reset_vec_fetch(rvf), .ram_keep(ram_keep), .osc_enable(osc_en),
    .sys_clk_en(sce), .io_hold(io_hold), .bus_drive_en(bde), .refresh_level_hold(rlh), .hold_req_ignore(hri),
    .hold_ack_force_low(hafl), .osc_in_ground(oig), .conv_run(conv_run), .conv_powered(conv_pw));

  sbyc_cpu_model cpu (.clk(clk), .rst_b(rst_b), .cfg(cfg), .ack_valid(ack_valid), .ack_src(ack_src),
    .cpu_resume(cpu_resume), .nmi_blocked(nmib), .isr_busy(busy), .isr_level(lvl), .ack_cnt(ack_cnt),
    .res_cnt(res_cnt), .last_src(last_src));

  // ----------------------------------------------------------------
  // Bus, pins and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cnt(input int da, input int dr);
    chk("acks", 32'(da), 32'(ack_cnt - a0));
    chk("resumes", 32'(dr), 32'(res_cnt - r0));
    a0 = ack_cnt;
    r0 = res_cnt;
  endtask : cnt

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic m);
    @(posedge clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    mov     <= m;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    mov     <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 4'hF, 1'h0);
  endtask : wr

  task automatic stby();
    apb(1'h1, OFS_STBY_CTRL, 32'h2, STRB_BYTE0, 1'h1);
  endtask : stby

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic pulse(input logic [1:0] i);
    @(posedge clk);
    if (i == 2'h3) wt <= 1'h1;
    else pins[i] <= 1'h1;
    @(posedge clk);
    wt <= 1'h0;
    repeat (3) @(posedge clk);
    pins <= 3'h0;
    tick(4);
  endtask : pulse

  task automatic wait_run();
    n = 0;
    while (sce !== 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    tick(3);
    chk("back in run", 32'h1, 32'(sce));
  endtask : wait_run

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    tick(1);
    chk("reset vector fetch", 32'h0, 32'(rvf));
    apb(1'h0, OFS_IRQ_MODE, 32'h0, 4'h0, 1'h0);
    chk("irq mode reset", 32'h7, rd);
    apb(1'h0, 8'h14, 32'h0, 4'h0, 1'h0);
    chk("unmapped error", 32'h1, 32'(err));
    $display("test reset done");
  endtask : t_reset

  task automatic t_refuse();
    apb(1'h1, OFS_STBY_CTRL, 32'h1, STRB_BYTE0, 1'h1);
    apb(1'h1, OFS_STBY_CTRL, 32'h2, 4'hF, 1'h1);
    apb(1'h1, OFS_STBY_CTRL, 32'h2, STRB_BYTE0, 1'h0);
    apb(1'h0, OFS_STATUS, 32'h0, 4'h0, 1'h0);
    chk("state after refused writes", 32'h0, rd & 32'h3);
    apb(1'h0, OFS_STBY_CTRL, 32'h0, 4'h0, 1'h0);
    chk("halt bit kept", 32'h1, rd);
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_stop();
    wr(OFS_OSC_SETTLE, 32'h2);
    wr(OFS_CONV_MODE, 32'h80);
    wr(OFS_IRQ_MODE, 32'h7107);
    stby();
    tick(1);
    chk("standby pins", 32'h0FB, 32'({sce, osc_en, bde, io_hold, rlh, hri, hafl, oig, conv_run, conv_pw,
        ram_keep}));
    pulse(2'h1);
    chk("masked wake", 32'h0, 32'(sce));
    @(posedge clk);
    pins[0] <= 1'h1;
    n = 0;
    while (osc_en !== 1'h1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (sce !== 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("settle span", 32'h1, 32'(n >= SET_EXP && n <= SET_EXP + 3));
    pins[0] <= 1'h0;
    tick(3);
    cnt(1, 0);
    chk("ack source", 32'(SBYC_ACK_NMI), 32'(last_src));
    $display("test stop done");
  endtask : t_stop

  task automatic t_nmi_blk();
    @(posedge clk);
    cfg <= 4'h8;
    stby();
    pulse(2'h0);
    wait_run();
    cnt(0, 1);
    apb(1'h0, OFS_STATUS, 32'h0, 4'h0, 1'h0);
    chk("nmi pending", 32'h1, (rd >> 4) & 32'h1);
    @(posedge clk);
    cfg <= 4'h0;
    tick(3);
    cnt(1, 0);
    $display("test nmi blocked done");
  endtask : t_nmi_blk

  task automatic t_mask();
    @(posedge clk);
    cfg <= 4'h6;
    wr(OFS_IRQ_MODE, 32'h17106);
    stby();
    tick(2);
    chk("entry refused", 32'h1, 32'(sce));
    cnt(0, 1);
    @(posedge clk);
    cfg <= 4'h0;
    tick(3);
    cnt(1, 0);
    @(posedge clk);
    cfg <= 4'h7;
    wr(OFS_IRQ_MODE, 32'h37106);
    stby();
    pulse(2'h1);
    wait_run();
    cnt(1, 0);
    chk("ack source", 32'(SBYC_ACK_A), 32'(last_src));
    wr(OFS_IRQ_MODE, 32'h37006);
    stby();
    pulse(2'h1);
    wait_run();
    cnt(0, 1);
    wr(OFS_IRQ_MODE, 32'h37106);
    tick(3);
    $display("test mask done");
  endtask : t_mask

  task automatic t_rst_stop();
    wr(OFS_OSC_SETTLE, 32'h82);
    wr(OFS_IRQ_MODE, 32'h7143);
    stby();
    tick(1);
    chk("oscillator input ground", 32'h0, 32'(oig));
    pulse(2'h3);
    tick(8);
    chk("transfer source wake", 32'h0, 32'(sce));
    @(posedge clk);
    rst_b <= 1'h0;
    tick(2);
    chk("reset outputs", 32'h7, 32'({rvf, sce, ram_keep}));
    @(posedge clk);
    rst_b <= 1'h1;
    tick(2);
    chk("fetch after release", 32'h0, 32'(rvf));
    $display("test reset in standby done");
  endtask : t_rst_stop

  // Ceiling is tens of times the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    t_reset();
    t_refuse();
    t_stop();
    t_nmi_blk();
    t_mask();
    t_rst_stop();
    end_sim();
  end
endmodule : tb

// >>> hdl/sbyc_settle.sv
// Purpose: Oscillator settle timer, base count shifted by the selection
// Assumes: start is a one-cycle pulse
// Notes:   A new start restarts the count
module sbyc_settle
  import sbyc_pkg::*;
#(
  parameter logic [SETTLE_CNT_W-1:0] BASE_CYC = SETTLE_CNT_W'(SETTLE_BASE_DEF)
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic [2:0] sel,
  output logic            done
);

  logic [SETTLE_CNT_W-1:0] count;
  logic                    busy;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= (BASE_CYC << sel) - SETTLE_CNT_W'(1);
        busy  <= 1'b1;
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - SETTLE_CNT_W'(1);
        end
      end
    end
  end

endmodule : sbyc_settle

// >>> hdl/sbyc_sync.sv
// Purpose: Two-stage synchroniser for asynchronous wake pins
// Assumes: Pins are slow compared with clk
// Notes:   Stage one feeds stage two only
module sbyc_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : sbyc_sync

// >>> hdl/sbyc_top.sv
// Purpose: Deep standby entry, pin state control and wake-up decision
// Assumes: Runs on an always-on clock; gates the system clock downstream
// Notes:   APB zero-wait slave; acknowledges pending wake requests
//
// Summary of operation
// RL1: Reset release pulses a reset-vector fetch; RAM is never cleared here.
// RL2: Writing stop bit one enters deep standby.
// RL3: Control write counts only as byte write from move-immediate.
// RL4: Pending wake condition at write blocks entry; resume or vector instead.
// RL5: Software clears pending requests before writing the stop bit.
// RL6: Standby stops oscillator and gates the system clock.
// RL7: Standby holds I/O lines and keeps RAM.
// RL8: Standby floats address/data, address, strobe and latch lines.
// RL9: Standby keeps refresh level, ignores hold request, drives hold ack low.
// RL10: Converter stops in standby; its run bit keeps it powered.
// RL11: Stop with external clock select zero grounds oscillator input.
// RL12: External clock systems set external clock select, drive inverted clock.
// RL13: Only NMI pin, two external pins, watch timer or reset wake.
// RL14: NMI wake acknowledged unless same or higher NMI routine runs.
// RL15: Blocked NMI wake resumes after the write, request stays pending.
// RL16: Pending requests are acknowledged once acknowledgment is possible.
// RL17: Unmasked, non-transfer, enabled wake acknowledged by priority rules.
// RL18: Blocked by priority or disabled: wake, resume, keep pending.
// RL19: Masked or transfer-enabled requests leave standby in place.
// RL20: Wake restarts oscillator and leaves after selected settle time.
// RL21: Reset ending standby keeps data memory.
//
// Register access over APB and the address map were chosen for this implementation.
module sbyc_top
  import sbyc_pkg::*;
#(
  parameter logic [SETTLE_CNT_W-1:0] SETTLE_BASE_CYC = SETTLE_CNT_W'(SETTLE_BASE_DEF)
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mov_imm_wr,
  input  wire logic        nmi_pin,
  input  wire logic        ext_request_a,
  input  wire logic        ext_request_b,
  input  wire logic        watch_timer_request,
  input  wire logic        nmi_blocked,
  input  wire logic        isr_busy,
  input  wire logic [1:0]  isr_level,
  output logic             ack_valid,
  output sbyc_src_t        ack_src,
  output logic             cpu_resume,
  output logic             reset_vec_fetch,
  output logic             ram_keep,
  output logic             osc_enable,
  output logic             sys_clk_en,
  output logic             io_hold,
  output logic             bus_drive_en,
  output logic             refresh_level_hold,
  output logic             hold_req_ignore,
  output logic             hold_ack_force_low,
  output logic             osc_in_ground,
  output logic             conv_run,
  output logic             conv_powered
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  sbyc_state_t state;
  logic        halt_select_bit;
  logic [2:0]  osc_sel;
  logic        external_clock_select;
  logic        conv_run_bit;
  logic [2:0]  request_mask_flag;
  logic [2:0]  auto_transfer_enable;
  logic        global_irq_enable;
  logic        level3_nesting_select;
  logic [2:0]  edge_rise;
  logic [5:0]  prio;
  logic [3:0]  pend;

  logic [2:0]  pin_s;
  logic [2:0]  pin_d;
  logic [3:0]  edge_hit;
  logic        wr_acc;
  logic        rd_setup;
  logic        ctrl_wr;
  logic        stop_req;
  logic        wake_cond;
  logic        stop_wake;
  logic        settle_done;
  logic        nmi_ok;
  logic [2:0]  mi_ok;
  logic        any_ok;
  logic        blocked_exit;
  logic        mapped;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Wake inputs
  // ----------------------------------------------------------------
  sbyc_sync #(.W(3)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({ext_request_b, ext_request_a, nmi_pin}),
    .dout  (pin_s)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_d <= 3'h0;
    end else begin
      pin_d <= pin_s;
    end
  end

  // Each pin picks rising or falling edge; the watch timer is a same-clock pulse
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      edge_hit[i] = edge_rise[i] ? (pin_s[i] & ~pin_d[i]) : (~pin_s[i] & pin_d[i]);
    end
    edge_hit[3] = watch_timer_request;
  end

  // ----------------------------------------------------------------
  // Acknowledge decision
  // ----------------------------------------------------------------
  assign nmi_ok = ~nmi_blocked; // RL14 RL15

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      mi_ok[i] = global_irq_enable & ~request_mask_flag[i] & ~auto_transfer_enable[i]
                 & (~isr_busy | (isr_level < prio[2*i +: 2])
                    | ((isr_level == LEVEL_TOP) & (prio[2*i +: 2] == LEVEL_TOP)
                       & ~level3_nesting_select)); // RL17 RL18
    end
  end

  assign any_ok = (pend[0] & nmi_ok) | (|(pend[3:1] & mi_ok));

  // Halt-style wake condition: mask alone decides, transfer enable ignored
  assign wake_cond = pend[0] | (|(pend[3:1] & ~request_mask_flag)); // RL4

  // In standby only unmasked, non-transfer sources count
  assign stop_wake = edge_hit[0]
                   | (|(edge_hit[3:1] & ~request_mask_flag & ~auto_transfer_enable)); // RL13 RL19

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  assign pready   = 1'b1;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped   = (paddr == OFS_STBY_CTRL) | (paddr == OFS_OSC_SETTLE) | (paddr == OFS_CONV_MODE)
                  | (paddr == OFS_IRQ_MODE) | (paddr == OFS_STATUS);
  assign pslverr  = psel & penable & (~mapped | (pwrite & (paddr == OFS_STATUS)));

  // Only a lone low-byte write from the move-immediate path may touch control
  assign ctrl_wr  = wr_acc & (paddr == OFS_STBY_CTRL) & (pstrb == STRB_BYTE0) & mov_imm_wr; // RL3
  assign stop_req = ctrl_wr & pwdata[CTRL_STOP_BIT] & (state == SBYC_RUN); // RL2

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      OFS_STBY_CTRL: begin
        rd_word[CTRL_HALT_BIT] = halt_select_bit;
        rd_word[CTRL_STOP_BIT] = (state != SBYC_RUN);
      end
      OFS_OSC_SETTLE: begin
        rd_word[OSC_SEL_LSB +: 3] = osc_sel;
        rd_word[OSC_EXTERNAL_CLOCK_SELECT_BIT]     = external_clock_select;
      end
      OFS_CONV_MODE: begin
        rd_word[CONV_RUN_BIT] = conv_run_bit;
      end
      OFS_IRQ_MODE: begin
        rd_word[IRQ_MASK_LSB +: 3] = request_mask_flag;
        rd_word[IRQ_ISM_LSB +: 3]  = auto_transfer_enable;
        rd_word[IRQ_IE_BIT]        = global_irq_enable;
        rd_word[IRQ_LEVEL3_NESTING_SELECT_BIT]      = level3_nesting_select;
        rd_word[IRQ_EDGE_LSB +: 3] = edge_rise;
        rd_word[IRQ_PRIO_LSB +: 6] = prio;
      end
      OFS_STATUS: begin
        rd_word[STAT_STATE_LSB +: 2] = state;
        rd_word[STAT_PEND_LSB +: 4]  = pend;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_word;
    end
  end

  // Configuration writes; byte strobes are honoured per lane
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_select_bit       <= 1'b0;
      osc_sel               <= OSC_SEL_RST;
      external_clock_select <= 1'b0;
      conv_run_bit          <= 1'b0;
      request_mask_flag     <= MASK_RST;
      auto_transfer_enable  <= 3'h0;
      global_irq_enable     <= 1'b0;
      level3_nesting_select <= 1'b0;
      edge_rise             <= 3'h0;
      prio                  <= 6'h00;
    end else begin
      if (ctrl_wr) begin
        halt_select_bit <= pwdata[CTRL_HALT_BIT]; // RL3
      end
      if (wr_acc & (paddr == OFS_OSC_SETTLE) & pstrb[0]) begin
        osc_sel               <= pwdata[OSC_SEL_LSB +: 3];
        external_clock_select <= pwdata[OSC_EXTERNAL_CLOCK_SELECT_BIT];
      end
      if (wr_acc & (paddr == OFS_CONV_MODE) & pstrb[0]) begin
        conv_run_bit <= pwdata[CONV_RUN_BIT];
      end
      if (wr_acc & (paddr == OFS_IRQ_MODE)) begin
        if (pstrb[0]) begin
          request_mask_flag    <= pwdata[IRQ_MASK_LSB +: 3];
          auto_transfer_enable <= pwdata[IRQ_ISM_LSB +: 3];
        end
        if (pstrb[1]) begin
          global_irq_enable     <= pwdata[IRQ_IE_BIT];
          level3_nesting_select <= pwdata[IRQ_LEVEL3_NESTING_SELECT_BIT];
          edge_rise             <= pwdata[IRQ_EDGE_LSB +: 3];
        end
        if (pstrb[2]) begin
          prio <= pwdata[IRQ_PRIO_LSB +: 6];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Standby sequence
  // ----------------------------------------------------------------
  sbyc_settle #(.BASE_CYC(SETTLE_BASE_CYC)) u_settle (
    .clk   (clk),
    .rst_b (rst_b),
    .start (state == SBYC_STOP && stop_wake),
    .sel   (osc_sel),
    .done  (settle_done)
  );

  // Reset always returns to run; that is the normal reset path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SBYC_RUN; // RL13
    end else begin
      case (state)
        SBYC_RUN: begin
          if (stop_req && !wake_cond) begin
            state <= SBYC_STOP; // RL2 RL4
          end
        end
        SBYC_STOP: begin
          if (stop_wake) begin
            state <= SBYC_SETTLE; // RL19
          end
        end
        SBYC_SETTLE: begin
          if (settle_done) begin
            state <= SBYC_RUN; // RL20
          end
        end
        default: begin
          state <= SBYC_RUN;
        end
      endcase
    end
  end

  // Pending requests; a new edge beats the acknowledge that clears it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (edge_hit[i]) begin
          pend[i] <= 1'b1;
        end else if (ack_valid && (ack_src == sbyc_src_t'(i))) begin
          pend[i] <= 1'b0; // RL16
        end
      end
    end
  end

  // Fixed order: NMI, then the two pins, then the watch timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_valid <= 1'b0;
      ack_src   <= SBYC_ACK_NMI;
    end else begin
      ack_valid <= 1'b0;
      if (state == SBYC_RUN && !ack_valid) begin
        if (pend[0] && nmi_ok) begin
          ack_valid <= 1'b1; // RL14 RL16
          ack_src   <= SBYC_ACK_NMI;
        end else if (pend[1] && mi_ok[SRC_A]) begin
          ack_valid <= 1'b1; // RL17
          ack_src   <= SBYC_ACK_A;
        end else if (pend[2] && mi_ok[SRC_B]) begin
          ack_valid <= 1'b1;
          ack_src   <= SBYC_ACK_B;
        end else if (pend[3] && mi_ok[SRC_W]) begin
          ack_valid <= 1'b1;
          ack_src   <= SBYC_ACK_W;
        end
      end
    end
  end

  // Resume after the write when leaving standby, or when entry was refused,
  // and nothing can be acknowledged
  assign blocked_exit = ((state == SBYC_SETTLE && settle_done) || (stop_req && wake_cond)) && !any_ok;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_resume <= 1'b0;
    end else begin
      cpu_resume <= blocked_exit; // RL15 RL18
    end
  end

  // Held high through reset, dropped one cycle after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_vec_fetch <= 1'b1;
    end else begin
      reset_vec_fetch <= 1'b0; // RL1
    end
  end

  // ----------------------------------------------------------------
  // Pin and clock control
  // ----------------------------------------------------------------
  assign ram_keep           = 1'b1; // RL1 RL7 RL21
  assign osc_enable         = (state != SBYC_STOP); // RL6 RL20
  assign sys_clk_en         = (state == SBYC_RUN); // RL6
  assign io_hold            = (state != SBYC_RUN); // RL7
  assign bus_drive_en       = (state == SBYC_RUN); // RL8
  assign refresh_level_hold = (state != SBYC_RUN); // RL9
  assign hold_req_ignore    = (state != SBYC_RUN); // RL9
  assign hold_ack_force_low = (state != SBYC_RUN); // RL9
  // Grounding the input while an external clock drives it would fight the source
  assign osc_in_ground      = (state == SBYC_STOP) && !external_clock_select; // RL11
  assign conv_run           = conv_run_bit && (state == SBYC_RUN); // RL10
  assign conv_powered       = conv_run_bit; // RL10

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_STOP_ENTER: assert property (stop_req && !wake_cond |=> state == SBYC_STOP) // RL2
    else $error("stop write did not enter standby");
  AST_BAD_WRITE: assert property (wr_acc && paddr == OFS_STBY_CTRL && (pstrb != STRB_BYTE0 || !mov_imm_wr)
                                  && state == SBYC_RUN |=> state == SBYC_RUN) // RL3
    else $error("illegal control write took effect");
  AST_NO_ENTRY: assert property (stop_req && wake_cond |=> state == SBYC_RUN && (ack_valid || cpu_resume)) // RL4
    else $error("entry with pending wake not refused");
  AST_CLK_OFF: assert property (state == SBYC_STOP |-> !osc_enable && !sys_clk_en && io_hold) // RL6
    else $error("clocks running in standby");
  AST_BUS_FLOAT: assert property (state != SBYC_RUN |-> !bus_drive_en && hold_ack_force_low
                                  && hold_req_ignore && refresh_level_hold) // RL8
    else $error("bus pins driven in standby");
  AST_X1_GND: assert property (state == SBYC_STOP && !external_clock_select |-> osc_in_ground) // RL11
    else $error("oscillator input not grounded");
  AST_CONV: assert property (state != SBYC_RUN |-> !conv_run && conv_powered == conv_run_bit) // RL10
    else $error("converter running in standby");
  AST_MASKED: assert property (state == SBYC_STOP && !stop_wake |=> state == SBYC_STOP) // RL19
    else $error("left standby without valid wake");
  AST_SETTLE: assert property (state == SBYC_STOP && stop_wake |=> state == SBYC_SETTLE [*2]) // RL20
    else $error("standby left before settle time");
  AST_NMI_ACK: assert property (state == SBYC_RUN && pend[0] && nmi_ok && !ack_valid
                                |=> ack_valid && ack_src == SBYC_ACK_NMI) // RL14
    else $error("pending NMI not acknowledged");
  AST_RESUME: assert property (state == SBYC_SETTLE && settle_done && !any_ok |=> cpu_resume && state == SBYC_RUN) // RL18
    else $error("blocked wake did not resume");
  AST_VEC: assert property (!reset_vec_fetch |=> !reset_vec_fetch) // RL1
    else $error("reset vector fetch repeated");

endmodule : sbyc_top

// >>> pkg/sbyc_pkg.sv
// Purpose: Shared constants for the deep standby controller
// Assumes: 32-bit APB, one word per register
// Notes:   Priority levels run 0 (lowest) to 3 (highest)
package sbyc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STBY_CTRL  = 8'h00;
  localparam logic [7:0] OFS_OSC_SETTLE = 8'h04;
  localparam logic [7:0] OFS_CONV_MODE  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MODE   = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_HALT_BIT   = 0;
  localparam int CTRL_STOP_BIT   = 1;
  localparam int OSC_SEL_LSB     = 0;
  localparam int OSC_EXTERNAL_CLOCK_SELECT_BIT    = 7;
  localparam int CONV_RUN_BIT    = 7;
  localparam int IRQ_MASK_LSB    = 0;
  localparam int IRQ_ISM_LSB     = 4;
  localparam int IRQ_IE_BIT      = 8;
  localparam int IRQ_LEVEL3_NESTING_SELECT_BIT    = 9;
  localparam int IRQ_EDGE_LSB    = 12;
  localparam int IRQ_PRIO_LSB    = 16;
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_PEND_LSB   = 4;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [2:0]  MASK_RST       = 3'h7;
  localparam logic [2:0]  OSC_SEL_RST    = 3'h0;
  localparam logic [1:0]  LEVEL_TOP      = 2'h3;
  localparam int          SETTLE_CNT_W   = 20;
  localparam int          SETTLE_BASE_DEF = 256;
  localparam logic [3:0]  STRB_BYTE0     = 4'h1;

  // Maskable sources: index into mask, transfer-enable and priority fields
  localparam int SRC_A = 0;
  localparam int SRC_B = 1;
  localparam int SRC_W = 2;

  typedef enum logic [1:0] {
    SBYC_ACK_NMI,
    SBYC_ACK_A,
    SBYC_ACK_B,
    SBYC_ACK_W
  } sbyc_src_t;

  typedef enum logic [1:0] {
    SBYC_RUN,
    SBYC_STOP,
    SBYC_SETTLE
  } sbyc_state_t;

endpackage : sbyc_pkg
